// ### aop_pkg.sv
package aop_pkg;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 8;
  // Least half period of the internal serial clock
  localparam int SCLK_HALF_NS = 16;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CNT_W = 6;
  localparam logic [4:0] BIT_LAST = 5'h0f;
  // Shared pin positions
  localparam int PIN_DIV_LO = 2;
  localparam int PIN_DIV_HI = 3;
  localparam int PIN_CLK_SRC = 4;
  localparam int PIN_SYNC_POL = 5;
  localparam int PIN_CLK_INV = 6;
  localparam int PIN_RMODE = 7;
  localparam int PIN_SDATA = 8;
  localparam int PIN_SCLK = 9;
  localparam int PIN_SYNC = 10;
  // Output enables, active low
  localparam logic [15:0] OE_N_PAR = 16'h0000;
  localparam logic [15:0] OE_N_SER_MASTER = 16'hf8ff;
  localparam logic [15:0] OE_N_SER_SLAVE = 16'hfaff;
  localparam logic [15:0] OE_N_RST = 16'hffff;
  localparam logic [15:0] PIN_RST = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  typedef enum logic [2:0] {
    AOP_MODE_NORMAL = 3'h1,
    AOP_MODE_FAST = 3'h2,
    AOP_MODE_LOWPWR = 3'h4
  } aop_mode_e;
  typedef enum logic [1:0] {
    AOP_ST_IDLE = 2'h1,
    AOP_ST_SHIFT = 2'h2
  } aop_state_e;
endpackage : aop_pkg

// ### aop_port.sv
`timescale 1ns/100ps

module aop_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic ready_ff;
  logic valid_ff;
  wire push = clk_en_i && in_valid_i && ready_ff;
  wire pop = clk_en_i && out_ready_i && valid_ff;
  wire [AW:0] cnt_up = push ? cnt_ff + CNT_ONE : cnt_ff;
  wire [AW:0] nxt_cnt = pop ? cnt_up - CNT_ONE : cnt_up;

  assign in_ready_o = ready_ff;
  assign out_valid_o = valid_ff;
  assign out_data_o = mem_ff[rd_ff];

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  // Flags registered from the next count, so both stay honest
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      ready_ff <= 1'b1;
      valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + AW'(1);
      end
      if (pop) begin
        rd_ff <= rd_ff + AW'(1);
      end
      cnt_ff <= nxt_cnt;
      ready_ff <= nxt_cnt != CNT_FULL;
      valid_ff <= nxt_cnt != '0;
    end
  end
endmodule : aop_fifo

module aop_port (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Static mode pins
  input wire logic fast_mode_select_i,
  input wire logic low_power_select_i,
  input wire logic port_select_i,
  output logic [2:0] conv_mode_o,
  // Conversion core, same clock
  input wire logic conv_busy_i,
  input wire logic result_valid_i,
  output logic result_ready_o,
  input wire logic [15:0] result_data_i,
  // Data bus pins, shared with the serial port
  input wire logic [15:0] data_pin_i,
  output logic [15:0] data_pin_o,
  output logic [15:0] data_pin_oe_n_o,
  input wire logic cs_n_pin_i
);
  logic [11:0] s1_ff;
  logic [11:0] s2_ff;
  logic sclk_d_ff;
  logic [2:0] mode_ff;
  aop_pkg::aop_state_e state_ff;
  logic [15:0] sreg_ff;
  logic [15:0] par_word_ff;
  logic [4:0] bit_ff;
  logic [5:0] cnt_ff;
  logic mclk_ff;
  logic [15:0] pin_ff;
  logic [15:0] oe_n_ff;
  logic fifo_valid;
  logic [15:0] fifo_dout;

  function automatic logic [2:0] mode_of(input logic fast,
                                         input logic lowp);
    if (lowp && !fast) begin
      mode_of = aop_pkg::AOP_MODE_LOWPWR;
    end else if (fast && !lowp) begin
      mode_of = aop_pkg::AOP_MODE_FAST;
    end else begin
      // Both high is undefined; fall back to normal
      mode_of = aop_pkg::AOP_MODE_NORMAL;
    end
  endfunction : mode_of

  // All pins are asynchronous to clk_sys_i
  wire [11:0] raw_pins = {cs_n_pin_i, port_select_i, low_power_select_i,
                          fast_mode_select_i, data_pin_i[9:2]};
  wire sclk_q = s2_ff[aop_pkg::PIN_SCLK-2];
  wire rmode_q = s2_ff[aop_pkg::PIN_RMODE-2];
  wire inv_q = s2_ff[aop_pkg::PIN_CLK_INV-2];
  wire pol_q = s2_ff[aop_pkg::PIN_SYNC_POL-2];
  wire ext_q = s2_ff[aop_pkg::PIN_CLK_SRC-2];
  wire [1:0] div_q = {s2_ff[aop_pkg::PIN_DIV_HI-2],
                      s2_ff[aop_pkg::PIN_DIV_LO-2]};
  wire fast_q = s2_ff[8];
  wire lowp_q = s2_ff[9];
  wire ser_q = s2_ff[10];
  wire cs_n_q = s2_ff[11];

  wire idle = state_ff == aop_pkg::AOP_ST_IDLE;
  wire shifting = state_ff == aop_pkg::AOP_ST_SHIFT;
  wire master = !ext_q;
  wire rac_mode = ser_q && master && !rmode_q;

  // Divider pins count only in read-after-convert master
  wire [1:0] div_eff = rac_mode ? div_q : 2'h0;
  wire [5:0] half_w = 6'(aop_pkg::SCLK_HALF_CYC) << div_eff;
  wire half_tick = cnt_ff == half_w - 6'h01;
  wire m_fall = shifting && master && half_tick && mclk_ff;
  wire m_done = m_fall && bit_ff == aop_pkg::BIT_LAST;

  // Slave update edge follows the inverted sense when asked
  wire s_cur = sclk_q ^ inv_q;
  wire s_prev = sclk_d_ff ^ inv_q;
  wire s_upd = shifting && ext_q && !cs_n_q && s_cur && !s_prev;

  // Read-during-convert starts while busy, else after completion
  wire m_go = rmode_q ? conv_busy_i : !conv_busy_i;
  wire s_go = !cs_n_q;
  wire start = ser_q && idle && fifo_valid && (master ? m_go : s_go);
  wire par_pop = !ser_q && fifo_valid;
  wire pop = start || par_pop;
  wire stop = !ser_q || m_done || (ext_q && cs_n_q);

  wire sdata_bit = sreg_ff[15];
  wire sclk_lvl = mclk_ff ^ inv_q;
  wire sync_lvl = shifting ^ pol_q;
  wire [15:0] ser_pins = {5'h00, sync_lvl, sclk_lvl, sdata_bit, 8'h00};
  wire [15:0] nxt_pin = ser_q ? ser_pins : par_word_ff;
  wire [15:0] ser_oe_n = master ? aop_pkg::OE_N_SER_MASTER
                                : aop_pkg::OE_N_SER_SLAVE;
  wire [15:0] nxt_oe_n = ser_q ? ser_oe_n : aop_pkg::OE_N_PAR;

  aop_fifo #(
    .WIDTH(aop_pkg::DATA_W),
    .DEPTH(aop_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .in_valid_i(result_valid_i),
    .in_ready_o(result_ready_o),
    .in_data_i(result_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_dout)
  );

  assign conv_mode_o = mode_ff;
  assign data_pin_o = pin_ff;
  assign data_pin_oe_n_o = oe_n_ff;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      sclk_d_ff <= 1'b0;
    end else if (clk_en_i) begin
      s1_ff <= raw_pins;
      s2_ff <= s1_ff;
      sclk_d_ff <= sclk_q;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ff <= aop_pkg::AOP_MODE_NORMAL;
    end else if (clk_en_i) begin
      mode_ff <= mode_of(fast_q, lowp_q);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= aop_pkg::AOP_ST_IDLE;
    end else if (clk_en_i) begin
      case (state_ff)
        aop_pkg::AOP_ST_IDLE: begin
          if (start) begin
            state_ff <= aop_pkg::AOP_ST_SHIFT;
          end
        end
        aop_pkg::AOP_ST_SHIFT: begin
          if (stop) begin
            state_ff <= aop_pkg::AOP_ST_IDLE;
          end
        end
        default: begin
          state_ff <= aop_pkg::AOP_ST_IDLE;
        end
      endcase
    end
  end

  // Chain input enters at the bottom; 16 shifts bring it out
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sreg_ff <= aop_pkg::WORD_RST;
      bit_ff <= 5'h00;
    end else if (clk_en_i) begin
      if (start) begin
        sreg_ff <= fifo_dout;
        bit_ff <= 5'h00;
      end else if (m_fall || s_upd) begin
        sreg_ff <= {sreg_ff[14:0], rmode_q};
        bit_ff <= bit_ff + 5'h01;
      end
    end
  end

  // Master clock idles low and rises first in each bit
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 6'h00;
      mclk_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (!shifting || ext_q) begin
        cnt_ff <= 6'h00;
        mclk_ff <= 1'b0;
      end else if (half_tick) begin
        cnt_ff <= 6'h00;
        mclk_ff <= !mclk_ff;
      end else begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      par_word_ff <= aop_pkg::WORD_RST;
    end else if (clk_en_i && par_pop) begin
      par_word_ff <= fifo_dout;
    end
  end

  // Pins registered; enables low while driving
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_ff <= aop_pkg::PIN_RST;
      oe_n_ff <= aop_pkg::OE_N_RST;
    end else if (clk_en_i) begin
      pin_ff <= nxt_pin;
      oe_n_ff <= nxt_oe_n;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_load;
    (start && clk_en_i) ##1 (clk_en_i && ser_q);
  endsequence

  mode_lowpwr_a: assert property (
    clk_en_i && lowp_q && !fast_q
      |=> conv_mode_o == aop_pkg::AOP_MODE_LOWPWR)
    else $error("reduced power mode not selected");

  mode_fast_a: assert property (
    clk_en_i && fast_q && !lowp_q
      |=> conv_mode_o == aop_pkg::AOP_MODE_FAST)
    else $error("fast mode not selected");

  mode_normal_a: assert property (
    clk_en_i && !fast_q && !lowp_q
      |=> conv_mode_o == aop_pkg::AOP_MODE_NORMAL)
    else $error("normal mode not selected");

  par_drive_a: assert property (
    clk_en_i && !ser_q |=> data_pin_oe_n_o == 16'h0000)
    else $error("parallel bus not driven");

  low_float_a: assert property (
    clk_en_i && ser_q |=> data_pin_oe_n_o[7:0] == 8'hff)
    else $error("serial mode drives low pins");

  div_float_a: assert property (
    clk_en_i && ser_q && !rac_mode |-> div_eff == 2'h0
      ##1 data_pin_oe_n_o[3:2] == 2'h3)
    else $error("divider pins used outside master rac");

  sclk_dir_a: assert property (
    clk_en_i && ser_q |=> data_pin_oe_n_o[9] == $past(ext_q))
    else $error("serial clock direction wrong");

  sync_idle_a: assert property (
    clk_en_i && ser_q && idle |=> data_pin_o[10] == $past(pol_q))
    else $error("frame sync not inactive when idle");

  frame_hold_a: assert property (
    clk_en_i && ser_q && shifting |=> data_pin_o[10] != $past(pol_q))
    else $error("frame sync not active in frame");

  rac_wait_a: assert property (
    start && master |-> (conv_busy_i == rmode_q))
    else $error("master read started at wrong time");

  msb_first_a: assert property (
    s_load |=> data_pin_o[8] == $past(fifo_dout[15], 2))
    else $error("first serial bit is not msb");
endmodule : aop_port

// ### aop_host.sv
`timescale 1ns/100ps

module aop_host (
  // Pins as the host sees them
  input wire logic clk_sys_i,
  input wire logic [15:0] pin_o_i,
  input wire logic [15:0] pin_oe_n_i,
  input wire logic [7:2] cfg_i,
  output logic [15:0] pin_i_o,
  // Host side
  output logic cs_n_o,
  output logic [15:0] rx_word_o
);
  logic ph_ff = 1'b0;
  logic mclk_ff = 1'b0;
  logic [15:0] host_w;
  logic mclk;
  logic is_master;

  // Released pins 15:10, 8 and 1:0 show the inverse of pin_o_i; pins 9 and 7:2 carry the host clock and cfg_i
  assign host_w = {~pin_o_i[15:10], ph_ff ^ cfg_i[6], ~pin_o_i[8],
                   cfg_i, ~pin_o_i[1:0]};
  assign pin_i_o = (pin_o_i & ~pin_oe_n_i) | (host_w & pin_oe_n_i);
  assign mclk = pin_o_i[9] ^ cfg_i[6];
  assign is_master = pin_oe_n_i === aop_pkg::OE_N_SER_MASTER;

  initial cs_n_o = 1'b1;
  initial rx_word_o = 16'h0000;

  // Master data is stable on the rising sense of the clock
  always @(posedge clk_sys_i) begin
    mclk_ff <= mclk;
    if (is_master && mclk && !mclk_ff && pin_o_i[10] !== cfg_i[5]) begin
      rx_word_o <= {rx_word_o[14:0], pin_o_i[8]};
    end
  end

  // Clock stands still unless selected
  task automatic slave_read(output logic last);
    cs_n_o = 1'b0;
    #64;
    for (int i = 0; i < 16; i++) begin
      rx_word_o = {rx_word_o[14:0], pin_o_i[8]};
      ph_ff = 1'b1;
      #62.5;
      ph_ff = 1'b0;
      #62.5;
    end
    #64;
    last = pin_o_i[8];
    cs_n_o = 1'b1;
  endtask : slave_read
endmodule : aop_host

// ### tb.sv
`timescale 1ns/100ps

module tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic en_i = 1'b1;
  logic fast_i = 1'b0;
  logic lowp_i = 1'b0;
  logic port_i = 1'b0;
  logic busy_i = 1'b0;
  logic valid_i = 1'b0;
  logic [15:0] data_i = 16'h0000;
  logic [7:2] cfg = 6'h00;
  logic [2:0] mode_o;
  logic ready_o;
  logic cs_n;
  logic [15:0] pin_o;
  logic [15:0] oe_n;
  logic [15:0] pin_i;
  logic [15:0] rx;
  int error_cnt = 0;
  int n_tests = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  aop_port u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(en_i),
    .fast_mode_select_i(fast_i), .low_power_select_i(lowp_i),
    .port_select_i(port_i), .conv_mode_o(mode_o),
    .conv_busy_i(busy_i), .result_valid_i(valid_i),
    .result_ready_o(ready_o), .result_data_i(data_i),
    .data_pin_i(pin_i), .data_pin_o(pin_o),
    .data_pin_oe_n_o(oe_n), .cs_n_pin_i(cs_n)
  );

  aop_host u_host (
    .clk_sys_i(clk_sys_i), .pin_o_i(pin_o), .pin_oe_n_i(oe_n),
    .cfg_i(cfg), .pin_i_o(pin_i), .cs_n_o(cs_n), .rx_word_o(rx)
  );

  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick

  task automatic push_n(input int cnt, input logic [15:0] base);
    valid_i = 1'b1;
    for (int k = 0; k < cnt; k++) begin
      data_i = base + k[15:0];
      // Ready is registered, so its settled value names the next edge
      for (int i = 0; ready_o !== 1'b1; i++) begin
        if (i == 40) begin
          chk("push ready", 16'h1, 16'h0);
          stop_test();
        end
        tick(1);
      end
      tick(1);
    end
    valid_i = 1'b0;
  endtask : push_n

  task automatic wait_sync(input logic lvl, input int max, output int n);
    for (n = 0; pin_o[10] !== lvl; n++) begin
      if (n == max) begin
        chk("sync wait", {15'h0, lvl}, {15'h0, ~lvl});
        stop_test();
      end
      tick(1);
    end
  endtask : wait_sync

  task automatic t_mode();
    logic [2:0] exp [4];
    exp = '{aop_pkg::AOP_MODE_NORMAL, aop_pkg::AOP_MODE_LOWPWR,
            aop_pkg::AOP_MODE_FAST, aop_pkg::AOP_MODE_NORMAL};
    for (int i = 0; i < 4; i++) begin
      {fast_i, lowp_i} = i[1:0];
      tick(4);
      chk("mode", {13'h0, exp[i]}, {13'h0, mode_o});
    end
  endtask : t_mode

  task automatic t_par();
    port_i = 1'b0;
    tick(4);
    push_n(1, 16'ha5c3);
    tick(4);
    chk("par data", 16'ha5c3, pin_o);
    chk("par oe_n", aop_pkg::OE_N_PAR, oe_n);
  endtask : t_par

  task automatic t_master(input logic [1:0] div, input logic inv, pol,
                          rmode, input logic [15:0] w);
    int n;
    int h;
    h = rmode ? 2 : 2 << div;
    cfg = {rmode, inv, pol, 1'b0, div};
    port_i = 1'b1;
    busy_i = 1'b1;
    tick(6);
    push_n(1, w);
    if (!rmode) begin
      tick(40);
      chk("early sync", {15'h0, pol}, {15'h0, pin_o[10]});
      busy_i = 1'b0;
    end
    wait_sync(~pol, 100, n);
    wait_sync(pol, 40 * h, n);
    chk("frame len", 16'(32 * h), n[15:0]);
    chk("master word", w, rx);
    chk("master oe_n", aop_pkg::OE_N_SER_MASTER, oe_n);
    busy_i = 1'b0;
  endtask : t_master

  task automatic t_slave(input logic inv, chain, input logic [15:0] w);
    logic last;
    cfg = {chain, inv, 1'b0, 1'b1, 2'h0};
    port_i = 1'b1;
    tick(6);
    push_n(1, w);
    tick(2);
    chk("slave oe_n", aop_pkg::OE_N_SER_SLAVE, oe_n);
    u_host.slave_read(last);
    chk("slave word", w, rx);
    chk("chain out", {15'h0, chain}, {15'h0, last});
  endtask : t_slave

  // Host stalls with chip select high, then parallel mode drains
  task automatic t_fifo();
    cfg = 6'h04;
    port_i = 1'b1;
    tick(6);
    push_n(8, 16'h1000);
    tick(2);
    chk("full ready", 16'h0, {15'h0, ready_o});
    valid_i = 1'b1;
    data_i = 16'hdead;
    tick(3);
    valid_i = 1'b0;
    port_i = 1'b0;
    tick(20);
    chk("drain ready", 16'h1, {15'h0, ready_o});
    chk("last word", 16'h1007, pin_o);
  endtask : t_fifo

  // Enable low must freeze the mode path, synchronisers included
  task automatic t_freeze();
    en_i = 1'b0;
    {fast_i, lowp_i} = 2'h2;
    tick(6);
    chk("frozen mode", 16'(aop_pkg::AOP_MODE_NORMAL), 16'(mode_o));
    en_i = 1'b1;
    tick(4);
    chk("thawed mode", 16'(aop_pkg::AOP_MODE_FAST), 16'(mode_o));
  endtask : t_freeze

  initial begin
    tick(5);
    chk("rst mode", 16'(aop_pkg::AOP_MODE_NORMAL), 16'(mode_o));
    chk("rst oe_n", aop_pkg::OE_N_RST, oe_n);
    rst_i = 1'b0;
    t_mode();
    t_par();
    t_master(2'h0, 1'b0, 1'b0, 1'b0, 16'h8001);
    t_master(2'h1, 1'b1, 1'b1, 1'b0, 16'h5a3c);
    t_master(2'h3, 1'b0, 1'b0, 1'b1, 16'hc0f5);
    t_slave(1'b0, 1'b1, 16'h9ab7);
    t_slave(1'b1, 1'b0, 16'h7e21);
    t_fifo();
    t_freeze();
    stop_test();
  end
endmodule : tb
